/* rtl/pas_shift_reg.sv */
// Four-stage parallel-access shift register with JK serial entry
//
// Summary of operation
// - Low clear empties all stages at once
// - Stages change only on rising clock pin or low clear
// - Load mode copies parallel inputs on edge
// - Parallel input n goes to stage n
// - Serial inputs ignored during parallel load
// - Shift mode moves one stage per edge
// - Data moves from first toward last stage
// - Serial pair decides first stage when shifting
// - JK pair clears, sets, holds or toggles
// - Without an edge or a low clear every stage holds
// - Stages take predecessor's pre-edge value together
// - Each stage drives its own output
`timescale 1ns/1ps
module pas_shift_reg
  import pas_pkg::*;
#(
  parameter int SYNC_DEPTH = PAS_SYNC_DEPTH
)(
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  input  wire logic  clear_n_pin,
  input  wire logic  load_select_pin,
  input  wire logic  clock_pin,
  input  wire logic  serial_j,
  input  wire logic  serial_k_n,
  input  wire logic  par_in0,
  input  wire logic  par_in1,
  input  wire logic  par_in2,
  input  wire logic  par_in3,
  output logic       stage0_out,
  output logic       stage1_out,
  output logic       stage2_out,
  output logic       stage3_out,
  output logic       stage3_out_n
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  localparam int PIN_W = 8;                 // Clock, mode, serial pair, four data

  logic [PIN_W-1:0]      pin_raw;
  logic [PIN_W-1:0]      pin_meta;          // First synchroniser rank
  logic [PIN_W-1:0]      pin_sync;          // Second synchroniser rank
  logic                  clk_pin_prev;      // Synced clock pin one cycle older
  logic                  pin_rise;
  logic                  shift_mode;
  logic [PAS_STAGES-1:0] par_sync;
  logic                  clr_all_n;
  logic [PAS_STAGES-1:0] stage;
  logic [PAS_STAGES-1:0] next_stage;

  pas_stage0_if s0 ();

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  assign pin_raw = {par_in3, par_in2, par_in1, par_in0,
                    serial_k_n, serial_j, load_select_pin, clock_pin};

  // Two ranks; only the second rank feeds any logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // Previous clock-pin level for edge detection
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_prev <= 1'b0;
    end else begin
      clk_pin_prev <= pin_sync[0];
    end
  end

  // Low-to-high transition of the clock pin, one cycle wide
  assign pin_rise   = pin_sync[0] & ~clk_pin_prev;
  assign shift_mode = pin_sync[1];
  assign par_sync   = pin_sync[7:4];

  // ---------------------------------------------------------------------------
  // First-stage serial logic
  // ---------------------------------------------------------------------------
  assign s0.serial_j   = pin_sync[2];
  assign s0.serial_k_n = pin_sync[3];
  assign s0.cur        = stage[PAS_FIRST];

  pas_first_stage u_first (
    .s0 (s0.stage)
  );

  // ---------------------------------------------------------------------------
  // Next stage contents
  // ---------------------------------------------------------------------------
  // Load copies the pins broadside; shift moves toward the last stage
  always_comb begin
    next_stage = stage;
    if (pin_rise) begin
      if (!shift_mode) begin
        next_stage = par_sync;
      end else begin
        next_stage[PAS_FIRST] = s0.nxt;
        next_stage[PAS_LAST:PAS_FIRST+1] = stage[PAS_LAST-1:PAS_FIRST];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Stage flops with direct overriding clear
  // ---------------------------------------------------------------------------
  // Clear pin acts without the clock, like the system reset
  assign clr_all_n = arst_n & clear_n_pin;

  always_ff @(posedge ref_clk or negedge clr_all_n) begin
    if (!clr_all_n) begin
      stage <= PAS_STAGE_RST;
    end else begin
      stage <= next_stage;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign stage0_out   = stage[0];
  assign stage1_out   = stage[1];
  assign stage2_out   = stage[2];
  assign stage3_out   = stage[3];
  assign stage3_out_n = ~stage[PAS_LAST];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_clear;
    @(posedge ref_clk) disable iff (!arst_n)
      !clear_n_pin |-> (stage == 4'h0) && stage3_out_n;
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not empty the stages");

  property p_load;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && !shift_mode |=> {stage3_out, stage2_out, stage1_out, stage0_out} == $past(par_sync);
  endproperty
  a_load: assert property (p_load) else $error("Parallel load did not copy inputs");

  // Loaded word against the raw pins, three samples back through the synchroniser
  property p_load_from_pins;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && !shift_mode |=>
        {stage3_out, stage2_out, stage1_out, stage0_out} == $past({par_in3, par_in2, par_in1, par_in0}, 3);
  endproperty
  a_load_from_pins: assert property (p_load_from_pins) else $error("Load order of pins is wrong");

  property p_shift;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && shift_mode |=> stage[3:1] == $past(stage[2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("Shift did not move data toward last stage");

  property p_hold;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      !pin_rise ##1 clear_n_pin |-> stage == $past(stage);
  endproperty
  a_hold: assert property (p_hold) else $error("Stage changed without a clock edge");

  property p_jk_clear;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && shift_mode && !pin_sync[2] && !pin_sync[3] |=> !stage0_out;
  endproperty
  a_jk_clear: assert property (p_jk_clear) else $error("Serial clear failed");

  property p_jk_set;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && shift_mode && pin_sync[2] && pin_sync[3] |=> stage0_out;
  endproperty
  a_jk_set: assert property (p_jk_set) else $error("Serial set failed");

  property p_jk_hold;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && shift_mode && !pin_sync[2] && pin_sync[3] |=> stage0_out == $past(stage0_out);
  endproperty
  a_jk_hold: assert property (p_jk_hold) else $error("Serial hold failed");

  property p_jk_toggle;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise && shift_mode && pin_sync[2] && !pin_sync[3] |=> stage0_out != $past(stage0_out);
  endproperty
  a_jk_toggle: assert property (p_jk_toggle) else $error("Serial toggle failed");

  property p_complement;
    @(posedge ref_clk) disable iff (!arst_n)
      stage3_out_n != stage3_out;
  endproperty
  a_complement: assert property (p_complement) else $error("Complement output not inverse");

  // One pin rise gives exactly one update; the cycle after it leaves the stages alone
  property p_edge_single;
    @(posedge ref_clk) disable iff (!arst_n || !clear_n_pin)
      pin_rise |=> ##1 stage == $past(stage);
  endproperty
  a_edge_single: assert property (p_edge_single) else $error("Stages updated twice per pin rise");

  // Edge detector against the raw clock pin, seen through both synchroniser ranks
  property p_edge_from_pin;
    @(posedge ref_clk) disable iff (!arst_n)
      pin_rise == ($past(clock_pin, 2) && !$past(clock_pin, 3));
  endproperty
  a_edge_from_pin: assert property (p_edge_from_pin) else $error("Pin rise seen at wrong cycle");

  // Mode used at an edge is the select pin with the same delay as the clock pin
  property p_mode_from_pin;
    @(posedge ref_clk) disable iff (!arst_n)
      pin_rise |-> shift_mode == $past(load_select_pin, 2);
  endproperty
  a_mode_from_pin: assert property (p_mode_from_pin) else $error("Mode taken from wrong pin");

  // Serial pair used at an edge comes from the J and inverted-K pins
  property p_serial_from_pins;
    @(posedge ref_clk) disable iff (!arst_n)
      pin_rise |-> {s0.serial_k_n, s0.serial_j} == $past({serial_k_n, serial_j}, 2);
  endproperty
  a_serial_from_pins: assert property (p_serial_from_pins) else $error("Serial pair from wrong pins");

endmodule // pas_shift_reg

/* rtl/pas_pkg.sv */
// Shared constants for the parallel-access shift register
package pas_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int          PAS_STAGES     = 4;      // Register length
  localparam int          PAS_SYNC_DEPTH = 2;      // Flops before any logic reads a pin other than clear_n_pin
  localparam logic [3:0]  PAS_STAGE_RST  = 4'h0;   // Stage contents after clear

  // ---------------------------------------------------------------------------
  // Field positions of the stage vector
  // ---------------------------------------------------------------------------
  localparam int          PAS_FIRST      = 0;      // Stage fed by the serial pair
  localparam int          PAS_LAST       = 3;      // Stage with the complement output

  // ---------------------------------------------------------------------------
  // First-stage serial actions, coded as {j, k_n}
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PAS_JK_CLEAR  = 2'h0,
    PAS_JK_HOLD   = 2'h1,
    PAS_JK_TOGGLE = 2'h2,
    PAS_JK_SET    = 2'h3
  } pas_jk_t;

endpackage : pas_pkg

/* rtl/pas_stage0_if.sv */
// Connection between the register core and its first-stage serial logic
`timescale 1ns/1ps
interface pas_stage0_if;
  logic serial_j;    // J serial input, synchronised
  logic serial_k_n;  // Inverted-K serial input, synchronised
  logic cur;         // Present first-stage value
  logic nxt;         // First-stage value after a shift edge

  modport core  (output serial_j, output serial_k_n, output cur, input nxt);
  modport stage (input serial_j, input serial_k_n, input cur, output nxt);
endinterface : pas_stage0_if

/* rtl/pas_first_stage.sv */
// Serial next-value logic of the first stage (JK, D or T behaviour)
`timescale 1ns/1ps
module pas_first_stage
  import pas_pkg::*;
(
  pas_stage0_if.stage  s0
);

  pas_jk_t action;

  // ---------------------------------------------------------------------------
  // Decode the serial pair into the first stage's next value
  // ---------------------------------------------------------------------------
  always_comb begin
    action = pas_jk_t'({s0.serial_j, s0.serial_k_n});
    case (action)
      PAS_JK_CLEAR:  s0.nxt = 1'b0;
      PAS_JK_HOLD:   s0.nxt = s0.cur;
      PAS_JK_TOGGLE: s0.nxt = ~s0.cur;
      PAS_JK_SET:    s0.nxt = 1'b1;
      default:       s0.nxt = s0.cur;
    endcase
  end

endmodule // pas_first_stage

/* testbench/pas_src.sv */
// Model of the surrounding logic that makes the device clock pulses
`timescale 1ns/1ps
module pas_src (
  input  wire logic  ref_clk,
  output logic       clock_pin
);
  initial clock_pin = 1'b0;

  // One rise on the device clock pin, all widths in ref_clk cycles.
  // The low lead-in gives the inputs time to settle before the rise.
  task automatic pulse(input int pre, input int hi, input int lo);
    repeat (pre) @(negedge ref_clk);
    clock_pin = 1'b1;
    repeat (hi) @(negedge ref_clk);
    clock_pin = 1'b0;
    repeat (lo) @(negedge ref_clk);
  endtask
endmodule // pas_src

/* testbench/tb_parallel_access_shift_register.sv */
// Self-checking bench for the parallel-access shift register
`timescale 1ns/1ps
module tb_parallel_access_shift_register;
  import pas_pkg::*;
  logic        ref_clk, arst_n, clear_n_pin, load_select_pin, serial_j, serial_k_n, clock_pin;
  logic        stage0_out, stage1_out, stage2_out, stage3_out, stage3_out_n;
  logic [3:0]  par, exp;
  logic [4:0]  outs;
  logic [31:0] seed;
  int          err_count, tests_run;

  assign outs = {stage3_out_n, stage3_out, stage2_out, stage1_out, stage0_out};

  pas_src u_src (.ref_clk(ref_clk), .clock_pin(clock_pin));
  pas_shift_reg u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .clear_n_pin(clear_n_pin),
    .load_select_pin(load_select_pin), .clock_pin(clock_pin), .serial_j(serial_j),
    .serial_k_n(serial_k_n), .par_in0(par[0]), .par_in1(par[1]), .par_in2(par[2]),
    .par_in3(par[3]), .stage0_out(stage0_out), .stage1_out(stage1_out),
    .stage2_out(stage2_out), .stage3_out(stage3_out), .stage3_out_n(stage3_out_n));

  // 5 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // Stage vector after one detected edge
  function automatic logic [3:0] next_val(input logic [3:0] cur, input logic sh, input logic j,
                                          input logic kn, input logic [3:0] p);
    logic f0;
    case ({j, kn})
      2'h0: f0 = 1'b0;
      2'h1: f0 = cur[0];
      2'h2: f0 = ~cur[0];
      default: f0 = 1'b1;
    endcase
    return sh ? {cur[2:0], f0} : p;
  endfunction

  task automatic chk(input logic [4:0] seen, input logic [4:0] want, input string msg);
    tests_run++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s seen %h want %h", $time, msg, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Present new inputs, confirm nothing moves without an edge, then clock once
  task automatic apply(input logic sh, input logic j, input logic kn, input logic [3:0] p);
    @(negedge ref_clk);
    load_select_pin = sh;
    serial_j = j;
    serial_k_n = kn;
    par = p;
    repeat (4) @(negedge ref_clk);
    chk(outs, {~exp[3], exp}, "hold");
    u_src.pulse(0, 4, 4);
    exp = next_val(exp, sh, j, kn, p);
    chk(outs, {~exp[3], exp}, "update");
  endtask

  // Hang guard
  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  initial begin
    {arst_n, clear_n_pin, load_select_pin, serial_j, serial_k_n} = 5'h0;
    par = 4'h0;
    exp = PAS_STAGE_RST;
    seed = 32'ha2d7;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    clear_n_pin = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(outs, 5'h10, "reset");
    // Loads with serial inputs set to disturb
    apply(1'b0, 1'b1, 1'b1, 4'h5);
    apply(1'b0, 1'b0, 1'b0, 4'ha);
    $display("test load done");
    // Every serial code from a first stage of 0; toggle and set also from 1
    for (int c = 0; c < 4; c++) begin
      apply(1'b0, 1'b0, 1'b1, 4'h6);
      apply(1'b1, c[1], c[0], 4'h9);
      apply(1'b1, c[1], c[0], 4'h0);
    end
    $display("test serial codes done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      apply(seed[0], seed[1], seed[2], seed[7:4]);
    end
    $display("test random done");
    // Back-to-back toggling edges, clock pin two ref_clk cycles high and two low
    apply(1'b1, 1'b1, 1'b0, 4'h0);
    u_src.pulse(0, 2, 2);
    u_src.pulse(0, 2, 2);
    repeat (4) @(negedge ref_clk);
    exp = next_val(next_val(exp, 1'b1, 1'b1, 1'b0, 4'h0), 1'b1, 1'b1, 1'b0, 4'h0);
    chk(outs, {~exp[3], exp}, "fast");
    $display("test back to back done");
    // Clear overrides state, mode and an edge given while clear is held
    apply(1'b0, 1'b1, 1'b1, 4'hf);
    clear_n_pin = 1'b0;
    exp = PAS_STAGE_RST;
    @(negedge ref_clk);
    chk(outs, 5'h10, "clear");
    u_src.pulse(0, 3, 3);
    chk(outs, 5'h10, "clear edge");
    clear_n_pin = 1'b1;
    repeat (3) @(negedge ref_clk);
    apply(1'b0, 1'b0, 1'b0, 4'h9);
    apply(1'b1, 1'b0, 1'b1, 4'h0);
    $display("test clear done");
    stop_test();
  end
endmodule // tb_parallel_access_shift_register
